// ### verilog/igo_init_override.sv
// init status pin, start-up clocking and device-wide output/clear override
`timescale 1ns/1ps
`include "igo_defs.svh"

module igo_init_override #(
    parameter int NUM_IO = 8,                      // user i/o count
    parameter logic [15:0] INIT_CYCLES = `IGO_INIT_CYCLES // init length in pacing ticks
) (
    input wire logic clk_sys,                      // system clock
    input wire logic sys_rst,                      // async reset, active high
    input wire logic config_request_n,             // pin, low holds configuration
    input wire logic cfg_data_done,                // config data fully loaded
    input wire logic frame1_valid,                 // first frame strobe
    input wire logic opt_usr_clk_en,               // option: use start-up clock
    input wire logic opt_done_en,                  // option: done output enabled
    input wire logic opt_oe_en,                    // option: global output enable pin
    input wire logic opt_clr_en,                   // option: global clear pin
    input wire logic user_startup_clock,           // pin, start-up pacing clock
    input wire logic global_output_enable,         // pin, low tri-states i/o
    input wire logic global_clear_n,               // pin, low clears registers
    input wire logic [NUM_IO-1:0] design_oe,       // design output enables
    output logic [NUM_IO-1:0] io_oe,               // final i/o enables
    output logic design_clear,                     // clear to design registers
    output logic done_out,                         // done pin output value
    output logic done_oe,                          // done pin drive enable
    output logic in_user_mode                      // device in user mode
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    igo_pkg::igo_state_s s_q, s_d; // registered and next state
    logic tick;                    // pacing tick

    // ----------------------------------------
    // next state
    // ----------------------------------------
    // pin inputs cost two cycles of latency; overrides are level controls,
    // so that delay is traded for freedom from metastable reads
    // synchronisers: first stage only feeds second stage
    always_comb begin
        s_d = s_q;
        s_d.cfg_n_m = config_request_n;
        s_d.cfg_n_s = s_q.cfg_n_m;
        s_d.usr_clk_m = user_startup_clock;
        s_d.usr_clk_s = s_q.usr_clk_m;
        s_d.usr_clk_p = s_q.usr_clk_s;
        s_d.oe_m = global_output_enable;
        s_d.oe_s = s_q.oe_m;
        s_d.clr_m = global_clear_n;
        s_d.clr_s = s_q.clr_m;
        // pacing: rising edge of start-up clock, else every system clock
        tick = opt_usr_clk_en ? (s_q.usr_clk_s & ~s_q.usr_clk_p) : 1'b1;
        if (!s_q.cfg_n_s) begin
            // configuration request low: phase back to ST_CONFIG, count and user mode cleared, pin floats
            s_d.phase = igo_pkg::ST_CONFIG;
            s_d.done_drive = 1'b0;
            s_d.user_mode = 1'b0;
            s_d.cnt = `IGO_CNT_ZERO;
        end else begin
            case (s_q.phase)
                igo_pkg::ST_UNCONF: begin
                    // leave power-up state once request is released
                    s_d.phase = igo_pkg::ST_CONFIG;
                end
                igo_pkg::ST_CONFIG: begin
                    // option bit lands with first frame
                    if (frame1_valid && opt_done_en) begin
                        s_d.done_drive = 1'b1;
                    end
                    // config data complete: start the init count
                    if (cfg_data_done) begin
                        s_d.phase = igo_pkg::ST_INIT;
                        s_d.cnt = INIT_CYCLES;
                    end
                end
                igo_pkg::ST_INIT: begin
                    // devices sharing the pacing clock finish together
                    if (tick) begin
                        if (s_q.cnt <= `IGO_CNT_ONE) begin
                            s_d.phase = igo_pkg::ST_USER;
                            s_d.done_drive = 1'b0;
                            s_d.user_mode = 1'b1;
                            s_d.cnt = `IGO_CNT_ZERO;
                        end else begin
                            // one pacing tick consumed
                            s_d.cnt = s_q.cnt - `IGO_CNT_ONE;
                        end
                    end
                end
                igo_pkg::ST_USER: begin
                    // stays here until request goes low again
                    s_d.user_mode = 1'b1;
                end
                default: begin
                    // unreachable encoding: restart safely
                    s_d.phase = igo_pkg::ST_UNCONF;
                end
            endcase
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    // override pins idle high after reset so nothing is forced by accident
    // request synchroniser resets low: first two edges act as request held
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            s_q <= '{cfg_n_m: 1'b0, cfg_n_s: 1'b0, usr_clk_m: 1'b0, usr_clk_s: 1'b0,
                     usr_clk_p: 1'b0, oe_m: 1'b1, oe_s: 1'b1, clr_m: 1'b1,
                     clr_s: 1'b1, done_drive: 1'b0, user_mode: 1'b0,
                     cnt: `IGO_CNT_ZERO, phase: igo_pkg::ST_UNCONF};
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // override only when its option is on; otherwise pin is ordinary i/o
    genvar gi;
    generate
        for (gi = 0; gi < NUM_IO; gi++) begin : g_io
            // low tri-states, high passes design enable
            assign io_oe[gi] = design_oe[gi] & (~opt_oe_en | s_q.oe_s);
        end
    endgenerate
    assign design_clear = opt_clr_en & ~s_q.clr_s;
    // high level comes from the board pull-up, never from this pin
    assign done_out = 1'b0;                 // open drain: only ever pulls low
    assign done_oe = s_q.done_drive;
    assign in_user_mode = s_q.user_mode;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    // request low releases the done pin on the next edge
    property p_float_in_request;
        @(posedge clk_sys) disable iff (sys_rst)
        !s_q.cfg_n_s |=> !done_oe;
    endproperty
    a_float_in_request: assert property (p_float_in_request) else $error("done driven");

    // first frame with the option set pulls done low
    property p_first_frame;
        @(posedge clk_sys) disable iff (sys_rst)
        (s_q.cfg_n_s && s_q.phase == igo_pkg::ST_CONFIG && frame1_valid && opt_done_en)
            |=> done_oe;
    endproperty
    a_first_frame: assert property (p_first_frame) else $error("done not driven low");

    // entering user mode coincides with release of done
    property p_release_user;
        @(posedge clk_sys) disable iff (sys_rst)
        $rose(in_user_mode) |-> !done_oe;
    endproperty
    a_release_user: assert property (p_release_user) else $error("done held in user mode");

    // pin low two edges ago, through the synchroniser, tri-states all
    property p_oe_off;
        @(posedge clk_sys) disable iff (sys_rst)
        (opt_oe_en && !$past(global_output_enable, 2) && !$past(sys_rst, 2))
            |-> (io_oe == '0);
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("i/o not tri-stated");

    // enable high passes the design enables untouched
    property p_oe_on;
        @(posedge clk_sys) disable iff (sys_rst)
        (opt_oe_en && s_q.oe_s) |-> (io_oe == design_oe);
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("i/o enable altered");

    // option is read in the same cycle as the clear, since it may change
    property p_clr_pin;
        @(posedge clk_sys) disable iff (sys_rst)
        (opt_clr_en && !$past(global_clear_n, 2) && !$past(sys_rst, 2))
            |-> design_clear;
    endproperty
    a_clr_pin: assert property (p_clr_pin) else $error("clear not forced");

    // clear pin high never forces a clear
    property p_clr_free;
        @(posedge clk_sys) disable iff (sys_rst)
        (opt_clr_en && s_q.clr_s) |-> !design_clear;
    endproperty
    a_clr_free: assert property (p_clr_free) else $error("clear forced while high");

    // options off: both pins behave as ordinary i/o
    property p_opts_off;
        @(posedge clk_sys) disable iff (sys_rst)
        (!opt_oe_en && !opt_clr_en) |-> (io_oe == design_oe) && !design_clear;
    endproperty
    a_opts_off: assert property (p_opts_off) else $error("override while option off");

    // with the user clock on, no tick means no progress
    property p_paced;
        @(posedge clk_sys) disable iff (sys_rst)
        (s_q.phase == igo_pkg::ST_INIT && opt_usr_clk_en && s_q.cfg_n_s
            && !(s_q.usr_clk_s && !s_q.usr_clk_p)) |=> $stable(s_q.cnt);
    endproperty
    a_paced: assert property (p_paced) else $error("init advanced without tick");

    // main scenarios: user mode, done driven, tri-state, clear, abort
    c_user: cover property (@(posedge clk_sys) disable iff (sys_rst) $rose(in_user_mode));
    c_drive: cover property (@(posedge clk_sys) disable iff (sys_rst) $rose(done_oe));
    c_tri: cover property (@(posedge clk_sys) disable iff (sys_rst) opt_oe_en && !s_q.oe_s);
    c_clr: cover property (@(posedge clk_sys) disable iff (sys_rst) design_clear);
    c_abort: cover property (@(posedge clk_sys) disable iff (sys_rst) done_oe && !s_q.cfg_n_s);
endmodule

// ### include/igo_defs.svh
// constants for the init status and global override block
`ifndef IGO_DEFS_SVH
`define IGO_DEFS_SVH
`define IGO_INIT_CYCLES 16'h0020
`define IGO_CNT_ZERO 16'h0000
`define IGO_CNT_ONE 16'h0001
`endif

// ### include/igo_pkg.sv
// types for the init status and global override block
package igo_pkg;
    typedef enum logic [1:0] {
        ST_UNCONF,
        ST_CONFIG,
        ST_INIT,
        ST_USER
    } igo_phase_e;
    // open-drain pin as three signals
    typedef struct packed {
        logic in;
        logic out;
        logic oe;
    } igo_pin_s;
    // module state
    typedef struct packed {
        logic cfg_n_m;
        logic cfg_n_s;
        logic usr_clk_m;
        logic usr_clk_s;
        logic usr_clk_p;
        logic oe_m;
        logic oe_s;
        logic clr_m;
        logic clr_s;
        logic done_drive;
        logic user_mode;
        logic [15:0] cnt;
        igo_phase_e phase;
    } igo_state_s;
endpackage

// ### bench/igo_board_model.sv
// board side model: pull-up on the done pin, ready watcher, start-up clock
`timescale 1ns/1ps

module igo_board_model (
    input wire logic clk_sys, // system clock
    input wire logic clk_run, // start-up clock runs while high
    input wire logic done_out, // done pin output value
    input wire logic done_oe, // done pin drive enable
    output logic done_wire, // resolved done pin level
    output logic ready_seen, // rising done pin seen
    output logic user_startup_clock, // start-up pacing clock
    output logic test_port_hold // test port held steady
);
    logic last_q; // previous done pin level
    logic [1:0] div_q; // start-up clock divider
    assign done_wire = done_oe ? done_out : 1'b1; // pull-up when released
    assign test_port_hold = 1'b1;
    // rising edge of the pin is the only ready sign
    always @(posedge clk_sys) begin
        ready_seen <= done_wire & ~last_q;
        last_q <= done_wire;
        div_q <= clk_run ? div_q + 2'h1 : 2'h0;
        // clock stands low while not running
        user_startup_clock <= clk_run & (div_q == 2'h3 ? ~user_startup_clock : user_startup_clock);
    end
    initial begin
        last_q = 1'b1;
        div_q = 2'h0;
        user_startup_clock = 1'b0;
    end
endmodule

// ### bench/test_init_status_global_override.sv
// self-checking bench for the init status and global override block
`timescale 1ns/1ps

module test_init_status_global_override;
    localparam int INIT = 4; // short init length
    logic clk_sys, sys_rst, config_request_n, cfg_data_done, frame1_valid;
    logic opt_usr_clk_en, opt_done_en, opt_oe_en, opt_clr_en, clk_run;
    logic user_startup_clock, global_output_enable, global_clear_n;
    logic [7:0] design_oe, io_oe;
    logic design_clear, done_out, done_oe, in_user_mode, done_wire, ready_seen;
    int error_cnt = 0;
    int samples_checked = 0;
    int cyc = 0;
    logic [16:0] rnd = 17'h17a6f; // lfsr state, seed 96879
    logic [7:0] e_oe; // model expectation

    igo_init_override #(.NUM_IO(8), .INIT_CYCLES(16'h0004)) igo_init_override_inst (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .config_request_n(config_request_n),
        .cfg_data_done(cfg_data_done), .frame1_valid(frame1_valid),
        .opt_usr_clk_en(opt_usr_clk_en), .opt_done_en(opt_done_en), .opt_oe_en(opt_oe_en),
        .opt_clr_en(opt_clr_en), .user_startup_clock(user_startup_clock),
        .global_output_enable(global_output_enable), .global_clear_n(global_clear_n),
        .design_oe(design_oe), .io_oe(io_oe), .design_clear(design_clear),
        .done_out(done_out), .done_oe(done_oe), .in_user_mode(in_user_mode));
    igo_board_model igo_board_model_inst (
        .clk_sys(clk_sys), .clk_run(clk_run), .done_out(done_out), .done_oe(done_oe),
        .done_wire(done_wire), .ready_seen(ready_seen),
        .user_startup_clock(user_startup_clock), .test_port_hold());

    function automatic logic [16:0] lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("errors %0d of %0d checks", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // one full configuration; user clock paced when asked; abort drops request after frame
    task automatic configure(input logic usr, input logic abort);
        opt_usr_clk_en = usr;
        clk_run = usr;
        config_request_n = 1'b0;
        tick(3);
        check("done_wire held", {7'h0, done_wire}, 8'h01);
        config_request_n = 1'b1;
        tick(4);
        check("done_oe early", {7'h0, done_oe}, 8'h00);
        frame1_valid = 1'b1;
        tick(1);
        frame1_valid = 1'b0;
        tick(1);
        check("done_oe frame", {7'h0, done_oe}, {7'h0, opt_done_en});
        check("done pin low", {7'h0, done_wire}, {7'h0, ~opt_done_en});
        if (abort) begin
            config_request_n = 1'b0;
            tick(3);
            check("done_oe abort", {7'h0, done_oe}, 8'h00);
            check("done pin float", {7'h0, done_wire}, 8'h01);
        end else begin
            cfg_data_done = 1'b1;
            tick(INIT);
            cfg_data_done = 1'b0;
            check("user early", {7'h0, in_user_mode}, 8'h00);
            for (int i = 0; i < 200 && in_user_mode !== 1'b1 && usr; i++) tick(1);
            if (!usr) tick(1);
            check("user mode", {7'h0, in_user_mode}, 8'h01);
            check("done released", {7'h0, done_wire}, 8'h01);
            // the watcher sees the risen pin one edge after release
            tick(1);
            check("ready pulse", {7'h0, ready_seen}, {7'h0, opt_done_en});
        end
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc > 5000) begin
            error_cnt++;
            test_done();
        end
    end
    initial begin
        {config_request_n, cfg_data_done, frame1_valid, opt_usr_clk_en, clk_run} = 5'h0;
        {opt_done_en, opt_oe_en, opt_clr_en} = 3'h7;
        {global_output_enable, global_clear_n} = 2'h3;
        design_oe = 8'h00;
        sys_rst = 1'b1;
        tick(8);
        sys_rst = 1'b0;
        tick(3);
        configure(1'b0, 1'b0);
        configure(1'b1, 1'b0);
        configure(1'b0, 1'b1);
        opt_done_en = 1'b0;
        configure(1'b0, 1'b0);
        // random override traffic, held 3 edges so the synchronisers settle
        for (int i = 0; i < 60; i++) begin
            rnd = lfsr(rnd);
            design_oe = rnd[7:0];
            {global_output_enable, global_clear_n, opt_oe_en, opt_clr_en} = rnd[11:8];
            tick(3);
            e_oe = (opt_oe_en && !global_output_enable) ? 8'h00 : design_oe;
            check("io_oe", io_oe, e_oe);
            check("clear", {7'h0, design_clear}, {7'h0, opt_clr_en & ~global_clear_n});
        end
        test_done();
    end
endmodule
